// >>> hdl/uaftr_pkg.sv
// constants shared by both ends of the flow and trigger register link
// assumes one clock, pclk at 40 MHz, and active-low asynchronous presetn
package uaftr_pkg;
  // ****************************************************************
  // register addresses on the 8-bit bus
  // ****************************************************************
  localparam logic [2:0] A_DLL    = 3'h0;
  localparam logic [2:0] A_DLH    = 3'h1;
  localparam logic [2:0] A_IER    = 3'h1;
  localparam logic [2:0] A_EFR    = 3'h2;
  localparam logic [2:0] A_FCR    = 3'h2;
  localparam logic [2:0] A_LCR    = 3'h3;
  localparam logic [2:0] A_MCR    = 3'h4;
  localparam logic [2:0] A_XON1   = 3'h4;
  localparam logic [2:0] A_XON2   = 3'h5;
  localparam logic [2:0] A_XOFF1  = 3'h6;
  localparam logic [2:0] A_XOFF2  = 3'h7;
  localparam logic [2:0] A_FLOW   = 3'h6;
  localparam logic [2:0] A_TRIG   = 3'h7;
  localparam logic [2:0] A_FRDY   = 3'h7;
  // ****************************************************************
  // field positions and values
  // ****************************************************************
  localparam logic [7:0] LCR_EFR_VIEW = 8'hbf;
  localparam logic [7:0] LCR_DIV_VIEW = 8'h80;
  localparam logic [7:0] LCR_NORMAL   = 8'h00;
  localparam int LCR_DIV_BIT   = 7;
  localparam int EFR_WE_BIT    = 4;
  localparam int EFR_ARTS_BIT  = 6;
  localparam int MCR_RTS_BIT   = 1;
  localparam int MCR_RDY_BIT   = 2;
  localparam int MCR_LOOP_BIT  = 4;
  localparam int MCR_EXT_BIT   = 6;
  localparam int MCR_PRESC_BIT = 7;
  localparam int LO_LSB        = 0;
  localparam int HI_LSB        = 4;
  localparam int FRDY_TX_LSB   = 0;
  localparam int FRDY_RX_LSB   = 4;
  localparam logic [7:0] IER_GATED = 8'hf0;
  localparam logic [7:0] FCR_GATED = 8'h30;
  localparam logic [7:0] MCR_GATED = 8'he0;
  localparam logic [7:0] EFR_UNLOCK = 8'h10;
  localparam logic [7:0] MCR_EXT    = 8'h40;
  localparam logic [7:0] MCR_NOLOOP = 8'hef;
  localparam logic [7:0] REG_RST    = 8'h00;
  // fifo-control trigger levels in bytes, index is the 2-bit select
  localparam logic [3:0][5:0] RX_FCR_LVL = {6'd60, 6'd56, 6'd16, 6'd8};
  localparam logic [3:0][5:0] TX_FCR_LVL = {6'd56, 6'd32, 6'd16, 6'd8};
  // ****************************************************************
  // host command registers on apb
  // ****************************************************************
  localparam logic [11:0] OFF_CMD  = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam int CMD_CHAN_BIT = 4;
  localparam int CMD_V1_LSB   = 8;
  localparam int CMD_V2_LSB   = 16;
  localparam int STAT_RES_LSB = 8;
  typedef enum logic [1:0] {OP_BAUD, OP_FLOW, OP_TRIG, OP_READY} uaftr_op_t;
endpackage

// >>> hdl/uaftr_if.sv
// 8-bit register bus between host sequencer and dual-channel device
// assumes both ends on pclk; strobes last one cycle, read data next cycle
`timescale 1ns/1ps
interface uaftr_if;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       wr_stb;
  logic       rd_stb;
  logic       chan_a_select_n;
  logic       chan_b_select_n;
  modport dev (
    input  addr,
    input  wdata,
    input  wr_stb,
    input  rd_stb,
    input  chan_a_select_n,
    input  chan_b_select_n,
    output rdata
  );
  modport hst (
    output addr,
    output wdata,
    output wr_stb,
    output rd_stb,
    output chan_a_select_n,
    output chan_b_select_n,
    input  rdata
  );
endinterface

// >>> hdl/uaftr_dev.sv
// device end: layered register views and flow/trigger registers, two channels
// assumes fifo fill and ready status arrive from logic on pclk
`timescale 1ns/1ps
module uaftr_dev (
  input  wire logic            pclk,
  input  wire logic            presetn,
  uaftr_if.dev                 bus,
  input  wire logic [1:0][6:0] rx_fill,
  input  wire logic [1:0]      tx_ready,
  input  wire logic [1:0]      rx_ready,
  output wire logic [1:0]      rts_n,
  output wire logic [1:0]      prescale_div4,
  output wire logic [1:0][5:0] halt_level,
  output wire logic [1:0][5:0] resume_level,
  output wire logic [1:0][5:0] rx_trigger,
  output wire logic [1:0][5:0] tx_trigger
);
  // ****************************************************************
  // shared decode
  // ****************************************************************
  wire logic [1:0] cs;
  wire logic [7:0] ready_word;
  wire logic [7:0] rd_val [2];
  wire logic [7:0] rd_pick;
  logic      [7:0] rdata;

  assign cs = {~bus.chan_b_select_n, ~bus.chan_a_select_n};
  // one status word for both channels, unused bits tied low
  assign ready_word = {2'b00, rx_ready, 2'b00, tx_ready};
  // channel a wins if both selects are low
  assign rd_pick = cs[0] ? rd_val[0] : (cs[1] ? rd_val[1] : 8'h00);
  assign bus.rdata = rdata;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata <= 8'h00;
    else if (bus.rd_stb)
      rdata <= rd_pick;
  end

  // ****************************************************************
  // per-channel registers
  // ****************************************************************
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    logic [7:0] line_control_reg, enhanced_feature_reg, modem_control_reg, ier, fifo_control_reg, dll, dlh;
    logic [7:0] xon1, xon2, xoff1, xoff2, flow, trig;
    logic       rts_q, presc_q;
    logic [5:0] halt_q, resume_q, rxt_q, txt_q;
    wire  logic       we, efr_view, div_view, norm_view, ext_we, auto_rts;
    wire  logic       rdy_on;
    wire  logic [2:0] a;
    wire  logic [7:0] d, next_ier, next_fcr, next_mcr;
    wire  logic [7:0] rv_efr, rv_div, rv_norm;
    wire  logic [5:0] next_halt, next_resume, next_rxt, next_txt;
    wire  logic [3:0] rx_fld, tx_fld;
    wire  logic       next_rts;

    assign a         = bus.addr;
    assign d         = bus.wdata;
    assign we        = bus.wr_stb & cs[c];
    assign efr_view  = (line_control_reg == uaftr_pkg::LCR_EFR_VIEW);
    assign div_view  = line_control_reg[uaftr_pkg::LCR_DIV_BIT] & ~efr_view;
    assign norm_view = ~line_control_reg[uaftr_pkg::LCR_DIV_BIT];
    // both bits must be set before the extended registers take a write
    assign ext_we = enhanced_feature_reg[uaftr_pkg::EFR_WE_BIT] & modem_control_reg[uaftr_pkg::MCR_EXT_BIT];
    // ready register only while enabled and not looped back
    assign rdy_on = modem_control_reg[uaftr_pkg::MCR_RDY_BIT] & ~modem_control_reg[uaftr_pkg::MCR_LOOP_BIT];
    assign auto_rts = enhanced_feature_reg[uaftr_pkg::EFR_ARTS_BIT];

    // gated bits (ier 7:4, fcr 5:4, mcr 7:5) keep their value unless enhanced writes are enabled
    assign next_ier = (d & ~uaftr_pkg::IER_GATED) |
                      ((enhanced_feature_reg[uaftr_pkg::EFR_WE_BIT] ? d : ier) & uaftr_pkg::IER_GATED);
    assign next_fcr = (d & ~uaftr_pkg::FCR_GATED) |
                      ((enhanced_feature_reg[uaftr_pkg::EFR_WE_BIT] ? d : fifo_control_reg) & uaftr_pkg::FCR_GATED);
    assign next_mcr = (d & ~uaftr_pkg::MCR_GATED) |
                      ((enhanced_feature_reg[uaftr_pkg::EFR_WE_BIT] ? d : modem_control_reg) & uaftr_pkg::MCR_GATED);

    // read views; the fifo-control register is write-only here
    assign rv_efr = (a == uaftr_pkg::A_EFR)   ? enhanced_feature_reg   :
                    (a == uaftr_pkg::A_LCR)   ? line_control_reg   :
                    (a == uaftr_pkg::A_XON1)  ? xon1  :
                    (a == uaftr_pkg::A_XON2)  ? xon2  :
                    (a == uaftr_pkg::A_XOFF1) ? xoff1 :
                    (a == uaftr_pkg::A_XOFF2) ? xoff2 : 8'h00;
    assign rv_div = (a == uaftr_pkg::A_DLL) ? dll :
                    (a == uaftr_pkg::A_DLH) ? dlh :
                    (a == uaftr_pkg::A_LCR) ? line_control_reg : 8'h00;
    assign rv_norm = (a == uaftr_pkg::A_IER) ? ier :
                     (a == uaftr_pkg::A_LCR) ? line_control_reg :
                     (a == uaftr_pkg::A_MCR) ? modem_control_reg :
                     (a == uaftr_pkg::A_FLOW && modem_control_reg[uaftr_pkg::MCR_EXT_BIT]) ? flow :
                     (a == uaftr_pkg::A_FRDY && rdy_on) ? ready_word :
                     (a == uaftr_pkg::A_TRIG && modem_control_reg[uaftr_pkg::MCR_EXT_BIT]) ? trig :
                     8'h00;
    assign rd_val[c] = efr_view ? rv_efr : (div_view ? rv_div : rv_norm);

    // levels in bytes: field shifted left by two
    assign next_halt   = {flow[uaftr_pkg::LO_LSB +: 4], 2'b00};
    assign next_resume = {flow[uaftr_pkg::HI_LSB +: 4], 2'b00};
    assign rx_fld = trig[uaftr_pkg::HI_LSB +: 4];
    assign tx_fld = trig[uaftr_pkg::LO_LSB +: 4];
    assign next_rxt = (rx_fld != 4'h0) ? {rx_fld, 2'b00} :
                      uaftr_pkg::RX_FCR_LVL[fifo_control_reg[7:6]];
    assign next_txt = (tx_fld != 4'h0) ? {tx_fld, 2'b00} :
                      uaftr_pkg::TX_FCR_LVL[fifo_control_reg[5:4]];
    // halt checked first, so a bad halt/resume pair still stops the sender
    assign next_rts = !auto_rts ? ~modem_control_reg[uaftr_pkg::MCR_RTS_BIT] :
                      (rx_fill[c] >= {1'b0, halt_q})   ? 1'b1 :
                      (rx_fill[c] <= {1'b0, resume_q}) ? 1'b0 : rts_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        line_control_reg <= uaftr_pkg::REG_RST;
        enhanced_feature_reg <= uaftr_pkg::REG_RST;
        modem_control_reg <= uaftr_pkg::REG_RST;
        ier <= uaftr_pkg::REG_RST;
        fifo_control_reg <= uaftr_pkg::REG_RST;
        dll <= uaftr_pkg::REG_RST;
        dlh <= uaftr_pkg::REG_RST;
        xon1 <= uaftr_pkg::REG_RST;
        xon2 <= uaftr_pkg::REG_RST;
        xoff1 <= uaftr_pkg::REG_RST;
        xoff2 <= uaftr_pkg::REG_RST;
        flow <= uaftr_pkg::REG_RST;
        trig <= uaftr_pkg::REG_RST;
      end
      else if (we)
      begin
        if (a == uaftr_pkg::A_LCR)
          line_control_reg <= d;
        if (efr_view && a == uaftr_pkg::A_EFR)
          enhanced_feature_reg <= d;
        if (efr_view && a == uaftr_pkg::A_XON1)
          xon1 <= d;
        if (efr_view && a == uaftr_pkg::A_XON2)
          xon2 <= d;
        if (efr_view && a == uaftr_pkg::A_XOFF1)
          xoff1 <= d;
        if (efr_view && a == uaftr_pkg::A_XOFF2)
          xoff2 <= d;
        if (div_view && a == uaftr_pkg::A_DLL)
          dll <= d;
        if (div_view && a == uaftr_pkg::A_DLH)
          dlh <= d;
        if (norm_view && a == uaftr_pkg::A_IER)
          ier <= next_ier;
        if (norm_view && a == uaftr_pkg::A_FCR)
          fifo_control_reg <= next_fcr;
        if (norm_view && a == uaftr_pkg::A_MCR)
          modem_control_reg <= next_mcr;
        if (norm_view && ext_we && a == uaftr_pkg::A_FLOW)
          flow <= d;
        if (norm_view && ext_we && a == uaftr_pkg::A_TRIG)
          trig <= d;
      end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        rts_q    <= 1'b1;
        presc_q  <= 1'b0;
        halt_q   <= 6'h00;
        resume_q <= 6'h00;
        rxt_q    <= 6'h00;
        txt_q    <= 6'h00;
      end
      else
      begin
        rts_q    <= next_rts;
        presc_q  <= modem_control_reg[uaftr_pkg::MCR_PRESC_BIT];
        halt_q   <= next_halt;
        resume_q <= next_resume;
        rxt_q    <= next_rxt;
        txt_q    <= next_txt;
      end
    end

    assign rts_n[c]         = rts_q;
    assign prescale_div4[c] = presc_q;
    assign halt_level[c]    = halt_q;
    assign resume_level[c]  = resume_q;
    assign rx_trigger[c]    = rxt_q;
    assign tx_trigger[c]    = txt_q;
  end
endmodule

// >>> hdl/uaftr_host.sv
// host end: apb command registers drive the layered access procedures
// assumes the device answers a read strobe with data on the next cycle
`timescale 1ns/1ps
module uaftr_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  uaftr_if.hst             bus
);
  typedef enum logic [3:0] {S_NONE, S_BF, S_80, S_00, S_T1, S_T2, S_T3, S_T2U,
                            S_T3X, S_T1R, S_V1, S_V2, S_VAL} uaftr_src_t;
  typedef enum logic [1:0] {D_T1, D_T2, D_T3, D_RES} uaftr_dst_t;
  typedef struct packed {
    logic       last;
    logic       rd;
    logic [2:0] a;
    uaftr_src_t src;
    uaftr_dst_t dst;
  } uaftr_step_t;
  typedef enum {H_IDLE, H_SETUP, H_STROBE, H_CAPT} uaftr_hst_t;

  // ****************************************************************
  // procedure tables
  // ****************************************************************
  function automatic uaftr_step_t mk(input logic l, input logic r, input logic [2:0] a,
                                     input uaftr_src_t s, input uaftr_dst_t d);
    mk = '{last: l, rd: r, a: a, src: s, dst: d};
  endfunction

  function automatic uaftr_step_t step(input uaftr_pkg::uaftr_op_t op,
                                       input logic [3:0] i, input logic [2:0] tgt);
    step = mk(1'b1, 1'b0, uaftr_pkg::A_LCR, S_T1, D_T1);
    if (op == uaftr_pkg::OP_BAUD)
      unique case (i)
        4'h0: step = mk(1'b0, 1'b1, uaftr_pkg::A_LCR, S_NONE, D_T1);
        4'h1: step = mk(1'b0, 1'b0, uaftr_pkg::A_LCR, S_80, D_T1);
        4'h2: step = mk(1'b0, 1'b0, uaftr_pkg::A_DLL, S_V1, D_T1);
        4'h3: step = mk(1'b0, 1'b0, uaftr_pkg::A_DLH, S_V2, D_T1);
        default: step = mk(1'b1, 1'b0, uaftr_pkg::A_LCR, S_T1, D_T1);
      endcase
    else if (op == uaftr_pkg::OP_READY)
      unique case (i)
        4'h0: step = mk(1'b0, 1'b1, uaftr_pkg::A_MCR, S_NONE, D_T1);
        4'h1: step = mk(1'b0, 1'b0, uaftr_pkg::A_MCR, S_T1R, D_T1);
        4'h2: step = mk(1'b0, 1'b1, uaftr_pkg::A_FRDY, S_NONE, D_RES);
        default: step = mk(1'b1, 1'b0, uaftr_pkg::A_MCR, S_T1, D_T1);
      endcase
    else
      unique case (i)
        4'h0: step = mk(1'b0, 1'b1, uaftr_pkg::A_LCR, S_NONE, D_T1);
        4'h1: step = mk(1'b0, 1'b0, uaftr_pkg::A_LCR, S_BF, D_T1);
        4'h2: step = mk(1'b0, 1'b1, uaftr_pkg::A_EFR, S_NONE, D_T2);
        4'h3: step = mk(1'b0, 1'b0, uaftr_pkg::A_EFR, S_T2U, D_T1);
        4'h4: step = mk(1'b0, 1'b0, uaftr_pkg::A_LCR, S_00, D_T1);
        4'h5: step = mk(1'b0, 1'b1, uaftr_pkg::A_MCR, S_NONE, D_T3);
        4'h6: step = mk(1'b0, 1'b0, uaftr_pkg::A_MCR, S_T3X, D_T1);
        4'h7: step = mk(1'b0, 1'b0, tgt, S_VAL, D_T1);
        4'h8: step = mk(1'b0, 1'b0, uaftr_pkg::A_MCR, S_T3, D_T1);
        4'h9: step = mk(1'b0, 1'b0, uaftr_pkg::A_LCR, S_BF, D_T1);
        4'ha: step = mk(1'b0, 1'b0, uaftr_pkg::A_EFR, S_T2, D_T1);
        default: step = mk(1'b1, 1'b0, uaftr_pkg::A_LCR, S_T1, D_T1);
      endcase
  endfunction

  // ****************************************************************
  // sequencer
  // ****************************************************************
  uaftr_hst_t            st;
  uaftr_pkg::uaftr_op_t  op;
  logic [3:0]            idx;
  logic                  chan;
  logic [7:0]            v1, v2, t1, t2, t3, res;
  wire  uaftr_step_t     cur;
  wire  logic [7:0]      wval;
  wire  logic            busy, acc, start;
  wire  logic [2:0]      tgt;

  assign tgt  = (op == uaftr_pkg::OP_TRIG) ? uaftr_pkg::A_TRIG : uaftr_pkg::A_FLOW;
  assign cur  = step(op, idx, tgt);
  assign busy = (st != H_IDLE);
  assign acc  = psel & penable & pready;
  assign start = acc & pwrite & (paddr == uaftr_pkg::OFF_CMD) & ~busy;
  assign wval = (cur.src == S_BF)  ? uaftr_pkg::LCR_EFR_VIEW :
                (cur.src == S_80)  ? uaftr_pkg::LCR_DIV_VIEW :
                (cur.src == S_00)  ? uaftr_pkg::LCR_NORMAL :
                (cur.src == S_T1)  ? t1 :
                (cur.src == S_T2)  ? t2 :
                (cur.src == S_T3)  ? t3 :
                (cur.src == S_T2U) ? (t2 | uaftr_pkg::EFR_UNLOCK) :
                (cur.src == S_T3X) ? (t3 | uaftr_pkg::MCR_EXT) :
                (cur.src == S_T1R) ? ((t1 & uaftr_pkg::MCR_NOLOOP) | uaftr_pkg::MCR_EXT) :
                (cur.src == S_V2)  ? v2 : v1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= H_IDLE;
      op <= uaftr_pkg::OP_BAUD;
      {idx, chan, v1, v2, t1, t2, t3, res} <= '0;
      bus.addr <= 3'h0;
      bus.wdata <= 8'h00;
      bus.wr_stb <= 1'b0;
      bus.rd_stb <= 1'b0;
      bus.chan_a_select_n <= 1'b1;
      bus.chan_b_select_n <= 1'b1;
    end
    else
    begin
      unique case (st)
        H_IDLE:
          if (start)
          begin
            op   <= uaftr_pkg::uaftr_op_t'(pwdata[1:0]);
            chan <= pwdata[uaftr_pkg::CMD_CHAN_BIT];
            v1   <= pwdata[uaftr_pkg::CMD_V1_LSB +: 8];
            v2   <= pwdata[uaftr_pkg::CMD_V2_LSB +: 8];
            idx  <= 4'h0;
            st   <= H_SETUP;
          end
        H_SETUP:
        begin
          bus.addr <= cur.a;
          bus.wdata <= wval;
          bus.wr_stb <= ~cur.rd;
          bus.rd_stb <= cur.rd;
          bus.chan_a_select_n <= chan;
          bus.chan_b_select_n <= ~chan;
          st <= H_STROBE;
        end
        H_STROBE:
        begin
          bus.wr_stb <= 1'b0;
          bus.rd_stb <= 1'b0;
          st <= H_CAPT;
        end
        H_CAPT:
        begin
          if (cur.rd)
            unique case (cur.dst)
              D_T1:  t1 <= bus.rdata;
              D_T2:  t2 <= bus.rdata;
              D_T3:  t3 <= bus.rdata;
              D_RES: res <= bus.rdata;
            endcase
          idx <= 4'(idx + 4'h1);
          if (cur.last)
          begin
            bus.chan_a_select_n <= 1'b1;
            bus.chan_b_select_n <= 1'b1;
            st <= H_IDLE;
          end
          else
            st <= H_SETUP;
        end
      endcase
    end
  end

  // ****************************************************************
  // apb slave, zero wait states
  // ****************************************************************
  wire logic        hit;
  wire logic [31:0] rval;
  assign hit  = (paddr == uaftr_pkg::OFF_CMD) | (paddr == uaftr_pkg::OFF_STAT);
  assign rval = (paddr == uaftr_pkg::OFF_STAT) ?
                {16'h0000, res, 7'h00, busy} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (psel & ~penable)
        prdata <= rval;
    end
  end
endmodule

// >>> sim/uaftr_checker.sv
// concurrent checks on the 8-bit register link between host and device
// assumes one pclk domain; only signals of uaftr_if and the reset are seen
`timescale 1ns/1ps
module uaftr_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic       chan_a_select_n,
  input wire logic       chan_b_select_n
);
  // ****************************************************************
  // shadows of the view and unlock registers
  // ****************************************************************
  // one shadow serves both channels: the host restores them after each command
  logic [7:0] lcr_sh;
  logic [7:0] efr_sh;
  logic [7:0] mcr_sh;
  wire        lcr_wr   = wr_stb && addr == 3'h3;
  wire        efr_wr   = wr_stb && addr == 3'h2 && lcr_sh == 8'hbf;
  wire        mcr_wr   = wr_stb && addr == 3'h4 && !lcr_sh[7];
  // upper modem bits only move while the write enable is set
  wire [7:0]  next_mcr = efr_sh[4] ? wdata : {mcr_sh[7:5], wdata[4:0]};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lcr_sh <= 8'h00;
      efr_sh <= 8'h00;
      mcr_sh <= 8'h00;
    end
    else
    begin
      if (lcr_wr) lcr_sh <= wdata;
      if (efr_wr) efr_sh <= wdata;
      if (mcr_wr) mcr_sh <= next_mcr;
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  div_view_a: assert property (wr_stb && addr == 3'h0 |-> lcr_sh == 8'h80)
    else $error("divisor write outside divisor view");
  feature_view_a: assert property (wr_stb && addr == 3'h2 |-> lcr_sh == 8'hbf)
    else $error("feature write outside feature view");
  flow_unlock_a: assert property (wr_stb && addr == 3'h6 && lcr_sh != 8'hbf
    |-> lcr_sh == 8'h00 && efr_sh[4] && mcr_sh[6]) else $error("threshold write while locked");
  trig_unlock_a: assert property (wr_stb && addr == 3'h7 && lcr_sh != 8'hbf
    |-> lcr_sh == 8'h00 && efr_sh[4] && mcr_sh[6]) else $error("trigger write while locked");
  lcr_back_a: assert property (rd_stb && addr == 3'h3 |=> rdata == lcr_sh)
    else $error("line control readback wrong");
  efr_back_a: assert property (rd_stb && addr == 3'h2 && lcr_sh == 8'hbf |=> rdata == efr_sh)
    else $error("feature readback wrong");
  mcr_gate_a: assert property (rd_stb && addr == 3'h4 && !lcr_sh[7] |=> rdata == mcr_sh)
    else $error("modem control gating wrong");
  restore_mcr_a: assert property (wr_stb && addr == 3'h7 && lcr_sh == 8'h00
    |=> !wr_stb [*2] ##1 (wr_stb && addr == 3'h4)) else $error("modem control not restored");
  one_chan_a: assert property (wr_stb || rd_stb |-> chan_a_select_n != chan_b_select_n)
    else $error("not exactly one channel selected");
  cover property (wr_stb && addr == 3'h6 && lcr_sh == 8'h00);
  cover property (wr_stb && addr == 3'h7 && lcr_sh == 8'h00);
  cover property (wr_stb && addr == 3'h0 && lcr_sh == 8'h80);
endmodule

// >>> sim/uart_flow_threshold_regs_test.sv
// self-checking bench: apb commands into the host, device levels observed
// assumes the host answers apb with zero waits and reports busy in STAT bit 0
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module uart_flow_threshold_regs_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0][6:0] rx_fill;
  logic [1:0] tx_ready, rx_ready, rts_n, prescale_div4;
  logic [1:0][5:0] halt_level, resume_level, rx_trigger, tx_trigger;
  logic [5:0] eh[2], erl[2], ert[2], ett[2];
  logic [7:0] v;
  int checks, bad_count, cyc, ch;
  // rows: {v2, v1, chan at bit 4, op}
  logic [31:0] rows[7] = '{32'h2801, 32'h3f11, 32'hf102, 32'h2012, 32'h341200, 32'h03, 32'h13};
  uaftr_if uaftr_if_i ();
  uaftr_dev uaftr_dev_i (.pclk, .presetn, .bus(uaftr_if_i.dev), .rx_fill, .tx_ready, .rx_ready,
    .rts_n, .prescale_div4, .halt_level, .resume_level, .rx_trigger, .tx_trigger);
  uaftr_host uaftr_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus(uaftr_if_i.hst));
  uaftr_checker uaftr_checker_i (.pclk, .presetn, .addr(uaftr_if_i.addr),
    .wdata(uaftr_if_i.wdata), .rdata(uaftr_if_i.rdata), .wr_stb(uaftr_if_i.wr_stb),
    .rd_stb(uaftr_if_i.rd_stb), .chan_a_select_n(uaftr_if_i.chan_a_select_n),
    .chan_b_select_n(uaftr_if_i.chan_b_select_n));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic give_verdict();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // the wait budget is 20000 cycles for the whole run
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic cmd(input logic [31:0] w);
    int n;
    n = 0;
    apb(1'b1, 12'h000, w);
    do begin apb(1'b0, 12'h004, 32'h0); n++; end while (rd[0] !== 1'b0 && n < 200);
  endtask
  task automatic chk_levels();
    for (int c = 0; c < 2; c++)
    begin
      `CHK("halt", eh[c], halt_level[c])
      `CHK("resume", erl[c], resume_level[c])
      `CHK("rx trigger", ert[c], rx_trigger[c])
      `CHK("tx trigger", ett[c], tx_trigger[c])
    end
  endtask
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; rx_fill = '0; tx_ready = 2'h0; rx_ready = 2'h0;
    eh = '{6'h00, 6'h00}; erl = eh; ert = '{6'h08, 6'h08}; ett = ert;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk_levels();
    rx_fill <= {7'h30, 7'h28}; tx_ready <= 2'h2; rx_ready <= 2'h1;
    foreach (rows[i])
    begin
      ch = rows[i][4]; v = rows[i][15:8];
      cmd(rows[i]);
      if (rows[i][1:0] == 2'h1) begin eh[ch] = {v[3:0], 2'b00}; erl[ch] = {v[7:4], 2'b00}; end
      if (rows[i][1:0] == 2'h2)
      begin
        ert[ch] = v[7:4] != 4'h0 ? {v[7:4], 2'b00} : 6'h08;
        ett[ch] = v[3:0] != 4'h0 ? {v[3:0], 2'b00} : 6'h08;
      end
      // the ready procedure leaves the enable clear, so address 7 reads nothing
      if (rows[i][1:0] == 2'h3) `CHK("ready word", 8'h00, rd[15:8])
      chk_levels();
    end
    `CHK("rts", 2'h3, rts_n)
    `CHK("prescale", 2'h0, prescale_div4)
    apb(1'b1, 12'h000, 32'h1301);
    cmd(32'h2401);
    eh[0] = 6'h0c; erl[0] = 6'h04;
    chk_levels();
    apb(1'b0, 12'h008, 32'h0);
    `CHK("slverr", 1'b1, er)
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // the trigger outputs load the fifo-control default one edge after release
    repeat (2) @(posedge pclk);
    eh = '{6'h00, 6'h00}; erl = eh; ert = '{6'h08, 6'h08}; ett = ert;
    chk_levels();
    give_verdict();
  end
endmodule
